// >>> hw/plane_compositor_map.svh
// Register offsets, field positions, reset values and timing counts of the compositor.
`ifndef PLANE_COMPOSITOR_MAP_SVH
`define PLANE_COMPOSITOR_MAP_SVH

// Register word offsets (byte addresses) of the control bank.
`define OFS_CTRL          12'h000
`define OFS_BG_COLOR      12'h004
`define OFS_VID_ALPHA     12'h008
`define OFS_CUR_POS       12'h00C
`define OFS_CUR_SIZE      12'h010
`define OFS_CLIP_MIN      12'h014
`define OFS_CLIP_MAX      12'h018
`define OFS_CUR_PTR       12'h01C
`define OFS_CUR_PITCH     12'h020
`define OFS_GFX_ADJ       12'h024
`define OFS_INS_DELAY     12'h028
`define OFS_STATUS        12'h02C
// Address bits [11:10] select the bank.
`define BANK_REGS         2'h0
`define BANK_CUR_PAL      2'h1
`define BANK_GFX_PAL      2'h2

// Control register fields.
`define CTRL_DOUBLE_BIT   0
`define CTRL_CUR_EN_BIT   1
`define CTRL_GFX_IDX_BIT  2
// Coordinate fields: x in [10:0], y in [26:16].
`define XY_X_LSB          0
`define XY_Y_LSB          16
// Graphics adjust: gain in [8:0] (0x080 is unity), signed offset in [25:16].
`define ADJ_GAIN_LSB      0
`define ADJ_OFS_LSB       16
// Insertion delay codes: rise in [3:0], fall in [7:4].
`define DLY_RISE_LSB      0
`define DLY_FALL_LSB      4

// Reset values.
`define RST_CTRL          32'h0000_0000
`define RST_BG_COLOR      24'h00_0000
`define RST_VID_ALPHA     8'hFF
`define RST_CUR_SIZE      8'h80
`define RST_CLIP_MAX      11'h7FF
`define RST_CUR_PITCH     16'h0080
`define RST_GAIN          9'h080
`define RST_DELAY_CODE    4'h7

// Timing: adaptor stage latency and code that gives zero offset.
`define ADAPTOR_STAGES    8
`define DELAY_ZERO_CODE   7
`define INS_TAPS          17

// BT.601 studio range to RGB, coefficients scaled by 256.
`define CSC_KY            12'h12A
`define CSC_KRV           12'h199
`define CSC_KGV           12'h0D0
`define CSC_KGU           12'h064
`define CSC_KBU           12'h204
`define CSC_Y_OFS         12'h040
`define CSC_C_OFS         12'h200

`endif

// >>> hw/plane_compositor_pkg.sv
// Types shared by the plane compositor and output adaptor.
package plane_compositor_pkg;
	typedef logic [9:0] comp_type;
	typedef logic [10:0] coord_type;
	typedef enum logic {
		RATE_SINGLE = 1'b0,
		RATE_DOUBLE = 1'b1
	} rate_mode_type;
endpackage : plane_compositor_pkg

// >>> hw/plane_compositor_output_adaptor.sv
// Four-plane compositor with colour space adaptor, up-sampler and insertion flag.
//
// Overview of operation
// - Mix four planes into one output stream.
// - Blend with 256 transparency levels.
// - Background is one opaque 24-bit register colour.
// - Background shows through remaining foreground transparency.
// - Video alpha over background adjusts video contrast.
// - Video YCbCr 4:4:4 10-bit, BT.601 to RGB.
// - Cursor 8-bit indices to ARGB4444, up to 128x128.
// - Cursor pixels outside clip window are transparent.
// - Cursor bitmap chosen by memory pointer register.
// - Cursor rows advance by programmable pitch.
// - Graphics ARGB 8:10:10:10 with gain and offset.
// - Graphics palette 8-bit ARGB, cursor palette 4-bit.
// - Video 4:2:2 upsampled to 4:4:4 first.
// - Composite 3x10-bit RGB enters colour space adaptor.
// - Adaptor output may be interpolated to double rate.
// - Single rate: samples pass unaltered.
// - Double rate: zero sample after each sample that is not directly followed by another sample.
// - Insertion flag high for graphics, low for video.
// - Flag edges delayed independently against output sync.
// - Edge at stage latency plus code minus seven.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "plane_compositor_map.svh"

module plane_compositor_output_adaptor
	import plane_compositor_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        pix_valid,
	input  wire coord_type   pix_x,
	input  wire coord_type   pix_y,
	input  wire logic        hsync_in,
	input  wire comp_type    vid_y,
	input  wire comp_type    vid_c,
	input  wire logic        vid_cb_phase,
	input  wire logic [37:0] gfx_argb,
	output logic             cur_rd_en,
	output logic [31:0]      cur_rd_addr,
	input  wire logic [7:0]  cur_rd_data,
	output logic             out_valid,
	output comp_type         out_r,
	output comp_type         out_g,
	output comp_type         out_b,
	output logic             hsync_out,
	output logic             graphics_insert_flag
);

	localparam int PAD = `ADAPTOR_STAGES - 4;

	// Signed matrix coefficients, so that negative products shift arithmetically.
	localparam logic signed [21:0] K_Y  = 22'(`CSC_KY);
	localparam logic signed [21:0] K_RV = 22'(`CSC_KRV);
	localparam logic signed [21:0] K_GV = 22'(`CSC_KGV);
	localparam logic signed [21:0] K_GU = 22'(`CSC_KGU);
	localparam logic signed [21:0] K_BU = 22'(`CSC_KBU);

	// Alpha blend of fg over bg; alpha 0..255 maps to weight 0..256.
	function automatic comp_type blend(input comp_type fg, input comp_type bg,
		input logic [7:0] a);
		logic [8:0]  w;
		logic [18:0] s;
		w = {1'b0, a} + {8'h00, a[7]};
		s = 19'(fg) * 19'(w) + 19'(bg) * 19'(9'h100 - w);
		return s[17:8];
	endfunction : blend

	// Saturate a signed value to the 10-bit component range.
	function automatic comp_type clamp10(input logic signed [21:0] v);
		if (v < 0) begin
			return 10'h000;
		end else if (v > 22'sh3FF) begin
			return 10'h3FF;
		end
		return v[9:0];
	endfunction : clamp10

	// Widen an 8-bit component to 10 bits by bit replication.
	function automatic comp_type widen8(input logic [7:0] c);
		return {c, c[7:6]};
	endfunction : widen8

	// Graphics gain (unity 0x80) and signed offset on one component.
	function automatic comp_type adjust(input comp_type c, input logic [8:0] g,
		input logic [9:0] o);
		logic signed [21:0] v;
		v = $signed({3'b000, 19'(c) * 19'(g)}) >>> 7;
		v = v + 22'(signed'(o));
		return clamp10(v);
	endfunction : adjust

	// Registers steering the block.
	logic [31:0] ctrl_q;
	logic [23:0] bg_color_q;
	logic [7:0]  vid_alpha_q;
	coord_type   cur_x_q, cur_y_q, clip_x0_q, clip_y0_q, clip_x1_q, clip_y1_q;
	logic [7:0]  cur_w_q, cur_h_q;
	logic [31:0] cur_ptr_q;
	logic [15:0] cur_pitch_q;
	logic [8:0]  gfx_gain_q;
	logic [9:0]  gfx_ofs_q;
	logic [3:0]  rise_code_q, fall_code_q;
	logic [15:0] cur_pal [256];
	logic [31:0] gfx_pal [256];

	logic        wr_en;
	logic [1:0]  bank;
	logic [7:0]  widx;
	rate_mode_type rate_mode;

	assign wr_en     = psel & penable & pwrite;
	assign bank      = paddr[11:10];
	assign widx      = paddr[9:2];
	assign pready    = 1'b1;
	assign rate_mode = rate_mode_type'(ctrl_q[`CTRL_DOUBLE_BIT]);

	// Control register writes at the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= `RST_CTRL;
			bg_color_q  <= `RST_BG_COLOR;
			vid_alpha_q <= `RST_VID_ALPHA;
			cur_x_q     <= '0;
			cur_y_q     <= '0;
			cur_w_q     <= `RST_CUR_SIZE;
			cur_h_q     <= `RST_CUR_SIZE;
			clip_x0_q   <= '0;
			clip_y0_q   <= '0;
			clip_x1_q   <= `RST_CLIP_MAX;
			clip_y1_q   <= `RST_CLIP_MAX;
			cur_ptr_q   <= '0;
			cur_pitch_q <= `RST_CUR_PITCH;
			gfx_gain_q  <= `RST_GAIN;
			gfx_ofs_q   <= '0;
			rise_code_q <= `RST_DELAY_CODE;
			fall_code_q <= `RST_DELAY_CODE;
		end else if (wr_en && bank == `BANK_REGS) begin
			unique case (paddr)
				`OFS_CTRL: ctrl_q <= {29'h0, pwdata[2:0]};
				`OFS_BG_COLOR: bg_color_q <= pwdata[23:0];
				`OFS_VID_ALPHA: vid_alpha_q <= pwdata[7:0];
				`OFS_CUR_POS: begin
					cur_x_q <= pwdata[`XY_X_LSB +: 11];
					cur_y_q <= pwdata[`XY_Y_LSB +: 11];
				end
				`OFS_CUR_SIZE: begin
					cur_w_q <= (pwdata[7:0] > `RST_CUR_SIZE) ? `RST_CUR_SIZE : pwdata[7:0];
					cur_h_q <= (pwdata[23:16] > `RST_CUR_SIZE) ? `RST_CUR_SIZE : pwdata[23:16];
				end
				`OFS_CLIP_MIN: begin
					clip_x0_q <= pwdata[`XY_X_LSB +: 11];
					clip_y0_q <= pwdata[`XY_Y_LSB +: 11];
				end
				`OFS_CLIP_MAX: begin
					clip_x1_q <= pwdata[`XY_X_LSB +: 11];
					clip_y1_q <= pwdata[`XY_Y_LSB +: 11];
				end
				`OFS_CUR_PTR: cur_ptr_q <= pwdata;
				`OFS_CUR_PITCH: cur_pitch_q <= pwdata[15:0];
				`OFS_GFX_ADJ: begin
					gfx_gain_q <= pwdata[`ADJ_GAIN_LSB +: 9];
					gfx_ofs_q  <= pwdata[`ADJ_OFS_LSB +: 10];
				end
				`OFS_INS_DELAY: begin
					rise_code_q <= pwdata[`DLY_RISE_LSB +: 4];
					fall_code_q <= pwdata[`DLY_FALL_LSB +: 4];
				end
				default: ;
			endcase
		end
	end

	// Palette writes; the palettes hold no reset value.
	always_ff @(posedge pclk) begin
		if (wr_en && bank == `BANK_CUR_PAL) begin
			cur_pal[widx] <= pwdata[15:0];
		end
		if (wr_en && bank == `BANK_GFX_PAL) begin
			gfx_pal[widx] <= pwdata;
		end
	end

	logic cur_hit_s3_q;

	// Read data and error are captured in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata  <= '0;
			unique case (bank)
				`BANK_CUR_PAL: prdata <= {16'h0000, cur_pal[widx]};
				`BANK_GFX_PAL: prdata <= gfx_pal[widx];
				`BANK_REGS: begin
					unique case (paddr)
						`OFS_CTRL:      prdata <= ctrl_q;
						`OFS_BG_COLOR:  prdata <= {8'h00, bg_color_q};
						`OFS_VID_ALPHA: prdata <= {24'h000000, vid_alpha_q};
						`OFS_CUR_POS:   prdata <= {5'h00, cur_y_q, 5'h00, cur_x_q};
						`OFS_CUR_SIZE:  prdata <= {8'h00, cur_h_q, 8'h00, cur_w_q};
						`OFS_CLIP_MIN:  prdata <= {5'h00, clip_y0_q, 5'h00, clip_x0_q};
						`OFS_CLIP_MAX:  prdata <= {5'h00, clip_y1_q, 5'h00, clip_x1_q};
						`OFS_CUR_PTR:   prdata <= cur_ptr_q;
						`OFS_CUR_PITCH: prdata <= {16'h0000, cur_pitch_q};
						`OFS_GFX_ADJ:   prdata <= {6'h00, gfx_ofs_q, 7'h00, gfx_gain_q};
						`OFS_INS_DELAY: prdata <= {24'h000000, fall_code_q, rise_code_q};
						`OFS_STATUS:    prdata <= {30'h0, cur_hit_s3_q, graphics_insert_flag};
						default:        pslverr <= 1'b1;
					endcase
				end
				default: pslverr <= 1'b1;
			endcase
		end
	end

	// Chroma held from the last Cb and Cr samples of the 4:2:2 stream.
	comp_type cb_q, cr_q, cb_now, cr_now;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cb_q <= 10'h200;
			cr_q <= 10'h200;
		end else if (pix_valid) begin
			if (vid_cb_phase) begin
				cb_q <= vid_c;
			end else begin
				cr_q <= vid_c;
			end
		end
	end
	assign cb_now = vid_cb_phase ? vid_c : cb_q;
	assign cr_now = vid_cb_phase ? cr_q : vid_c;

	// Colour matrix from studio range YCbCr to RGB.
	logic signed [21:0] yo, uo, vo;
	comp_type csc_r, csc_g, csc_b;
	always_comb begin
		yo = 22'(signed'({1'b0, vid_y})) - 22'(signed'({1'b0, `CSC_Y_OFS}));
		uo = 22'(signed'({1'b0, cb_now})) - 22'(signed'({1'b0, `CSC_C_OFS}));
		vo = 22'(signed'({1'b0, cr_now})) - 22'(signed'({1'b0, `CSC_C_OFS}));
		csc_r = clamp10((yo * K_Y + vo * K_RV) >>> 8);
		csc_g = clamp10((yo * K_Y - vo * K_GV - uo * K_GU) >>> 8);
		csc_b = clamp10((yo * K_Y + uo * K_BU) >>> 8);
	end

	// Graphics source: direct ARGB or indexed through the 8-bit palette.
	logic [31:0] gpal;
	logic [7:0]  g_a;
	comp_type    g_r, g_g, g_b;
	logic        ins_raw;
	assign gpal = gfx_pal[gfx_argb[7:0]];
	always_comb begin
		if (ctrl_q[`CTRL_GFX_IDX_BIT]) begin
			g_a = gpal[31:24];
			g_r = widen8(gpal[23:16]);
			g_g = widen8(gpal[15:8]);
			g_b = widen8(gpal[7:0]);
		end else begin
			g_a = gfx_argb[37:30];
			g_r = gfx_argb[29:20];
			g_g = gfx_argb[19:10];
			g_b = gfx_argb[9:0];
		end
	end
	assign ins_raw = pix_valid & (g_a != 8'h00);

	// Cursor hit test, clip window and bitmap address.
	logic [10:0] dx, dy;
	logic        in_cur, in_clip;
	assign dx = pix_x - cur_x_q;
	assign dy = pix_y - cur_y_q;
	assign in_cur = pix_x >= cur_x_q && pix_y >= cur_y_q &&
		dx < {3'b000, cur_w_q} && dy < {3'b000, cur_h_q};
	assign in_clip = pix_x >= clip_x0_q && pix_x <= clip_x1_q &&
		pix_y >= clip_y0_q && pix_y <= clip_y1_q;

	// Stage 1: video over background, graphics adjusted, cursor fetch issued.
	logic     v1_q, hs1_q, hit1_q;
	comp_type c1_r_q, c1_g_q, c1_b_q, g1_r_q, g1_g_q, g1_b_q;
	logic [7:0] g1_a_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v1_q <= 1'b0; hs1_q <= 1'b0; hit1_q <= 1'b0;
			c1_r_q <= '0; c1_g_q <= '0; c1_b_q <= '0;
			g1_r_q <= '0; g1_g_q <= '0; g1_b_q <= '0; g1_a_q <= '0;
			cur_rd_en <= 1'b0; cur_rd_addr <= '0;
		end else begin
			v1_q  <= pix_valid;
			hs1_q <= hsync_in;
			c1_r_q <= blend(csc_r, widen8(bg_color_q[23:16]), vid_alpha_q);
			c1_g_q <= blend(csc_g, widen8(bg_color_q[15:8]), vid_alpha_q);
			c1_b_q <= blend(csc_b, widen8(bg_color_q[7:0]), vid_alpha_q);
			g1_r_q <= adjust(g_r, gfx_gain_q, gfx_ofs_q);
			g1_g_q <= adjust(g_g, gfx_gain_q, gfx_ofs_q);
			g1_b_q <= adjust(g_b, gfx_gain_q, gfx_ofs_q);
			g1_a_q <= g_a;
			hit1_q <= pix_valid & ctrl_q[`CTRL_CUR_EN_BIT] & in_cur & in_clip;
			cur_rd_en <= pix_valid & ctrl_q[`CTRL_CUR_EN_BIT] & in_cur & in_clip;
			cur_rd_addr <= cur_ptr_q + 32'(dy[6:0]) * 32'(cur_pitch_q) + 32'(dx[6:0]);
		end
	end

	// Stage 2: graphics over the video result; cursor index arrives.
	logic     v2_q, hs2_q, hit2_q;
	comp_type c2_r_q, c2_g_q, c2_b_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v2_q <= 1'b0; hs2_q <= 1'b0; hit2_q <= 1'b0;
			c2_r_q <= '0; c2_g_q <= '0; c2_b_q <= '0;
		end else begin
			v2_q <= v1_q; hs2_q <= hs1_q; hit2_q <= hit1_q;
			c2_r_q <= blend(g1_r_q, c1_r_q, g1_a_q);
			c2_g_q <= blend(g1_g_q, c1_g_q, g1_a_q);
			c2_b_q <= blend(g1_b_q, c1_b_q, g1_a_q);
		end
	end

	// Stage 3: cursor on top; a miss counts as fully transparent.
	logic [15:0] cpal;
	logic [7:0]  cur_a;
	logic        v3_q, hs3_q;
	comp_type    c3_r_q, c3_g_q, c3_b_q;
	// A miss reads no palette entry, so its colour and alpha are both zero.
	assign cpal = hit2_q ? cur_pal[cur_rd_data] : 16'h0000;
	assign cur_a = hit2_q ? {cpal[15:12], cpal[15:12]} : 8'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v3_q <= 1'b0; hs3_q <= 1'b0; cur_hit_s3_q <= 1'b0;
			c3_r_q <= '0; c3_g_q <= '0; c3_b_q <= '0;
		end else begin
			v3_q <= v2_q; hs3_q <= hs2_q; cur_hit_s3_q <= hit2_q;
			c3_r_q <= blend(10'({3{cpal[11:8]}} >> 2), c2_r_q, cur_a);
			c3_g_q <= blend(10'({3{cpal[7:4]}} >> 2), c2_g_q, cur_a);
			c3_b_q <= blend(10'({3{cpal[3:0]}} >> 2), c2_b_q, cur_a);
		end
	end

	// adaptor stages; RGB passes through to keep the latency fixed.
	logic [30:0] pad_q [PAD];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PAD; i++) begin
				pad_q[i] <= '0;
			end
		end else begin
			pad_q[0] <= {v3_q, c3_r_q, c3_g_q, c3_b_q};
			for (int i = 1; i < PAD; i++) begin
				pad_q[i] <= pad_q[i - 1];
			end
		end
	end
	logic [PAD-1:0] hs_pad_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_pad_q <= '0;
		end else begin
			hs_pad_q <= {hs_pad_q[PAD-2:0], hs3_q};
		end
	end

	// Up-sampler output register.
	logic [30:0] last;
	logic        zero_due_q;
	assign last = pad_q[PAD-1];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			zero_due_q <= 1'b0;
			out_r <= '0; out_g <= '0; out_b <= '0;
			hsync_out <= 1'b0;
		end else begin
			hsync_out <= hs_pad_q[PAD-1];
			zero_due_q <= last[30];
			unique case (rate_mode)
				RATE_SINGLE: begin
					out_valid <= last[30];
					if (last[30]) begin
						{out_r, out_g, out_b} <= last[29:0];
					end
				end
				RATE_DOUBLE: begin
					out_valid <= last[30] | zero_due_q;
					{out_r, out_g, out_b} <= last[30] ? last[29:0] : 30'h0;
				end
			endcase
		end
	end

	// Insertion flag delay taps; tap k is the raw flag k cycles old.
	logic [`INS_TAPS-2:0] ins_sr_q;
	logic [`INS_TAPS-1:0] taps;
	assign taps = {ins_sr_q, ins_raw};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ins_sr_q <= '0;
		end else begin
			ins_sr_q <= {ins_sr_q[`INS_TAPS-3:0], ins_raw};
		end
	end

	// independent edge delays; a rise wins over a fall.
	logic rise_seen, fall_seen;
	assign rise_seen = taps[rise_code_q] & ~taps[5'(rise_code_q) + 5'h01];
	assign fall_seen = ~taps[fall_code_q] & taps[5'(fall_code_q) + 5'h01];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			graphics_insert_flag <= 1'b0;
		end else if (rise_seen) begin
			graphics_insert_flag <= 1'b1;
		end else if (fall_seen) begin
			graphics_insert_flag <= 1'b0;
		end
	end

endmodule : plane_compositor_output_adaptor
`default_nettype wire

// >>> tb/cursor_memory_model.sv
// Synchronous cursor bitmap memory that answers each fetch on the next cycle.
`timescale 1ns/100ps
`default_nettype none
module cursor_memory_model (
	input  wire logic        clk,
	input  wire logic        rd_en,
	input  wire logic [31:0] rd_addr,
	output logic [7:0]       rd_data
);
	// indexed fetch.
	// The index follows the address; between fetches the line toggles so stale data never passes.
	always_ff @(posedge clk) begin
		if (rd_en)
			rd_data <= rd_addr[7:0] ^ 8'h5A;
		else
			rd_data <= ~rd_data;
	end
endmodule : cursor_memory_model
`default_nettype wire

// >>> tb/plane_compositor_output_adaptor_properties.sv
// Concurrent checks of stream latency, up-sampling and insertion flag timing.
`timescale 1ns/100ps
`default_nettype none
`include "plane_compositor_map.svh"
module plane_compositor_output_adaptor_properties
	import plane_compositor_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pix_valid,
	input wire logic        hsync_in,
	input wire logic [37:0] gfx_argb,
	input wire logic        out_valid,
	input wire comp_type    out_r,
	input wire comp_type    out_g,
	input wire comp_type    out_b,
	input wire logic        hsync_out,
	input wire logic        graphics_insert_flag
);
	logic [2:0]  ctrl_q;
	logic [7:0]  dly_q;
	logic [4:0]  quiet_q;
	logic [16:0] raw_q;
	wire logic   wr   = psel && penable && pwrite;
	wire logic   raw  = pix_valid && gfx_argb[37:30] != 8'h00;
	wire logic   calm = quiet_q == 5'h1F;
	wire logic   dbl  = ctrl_q[`CTRL_DOUBLE_BIT];
	wire logic   ok   = calm && !ctrl_q[`CTRL_GFX_IDX_BIT];
	wire logic   rise = raw_q[dly_q[3:0]] && !raw_q[dly_q[3:0] + 5'h01];
	wire logic   fall = raw_q[dly_q[7:4] + 5'h01] && !raw_q[dly_q[7:4]];

	// Mirror of mode and delay codes; checks wait until the pipeline has settled on them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= 3'h0;
			dly_q   <= 8'h77;
			quiet_q <= 5'h00;
		end else begin
			if (wr && paddr == `OFS_CTRL)
				ctrl_q <= pwdata[2:0];
			if (wr && paddr == `OFS_INS_DELAY)
				dly_q <= pwdata[7:0];
			if (wr && (paddr == `OFS_CTRL || paddr == `OFS_INS_DELAY))
				quiet_q <= 5'h00;
			else if (!calm)
				quiet_q <= quiet_q + 5'h01;
		end
	end

	// History of graphics presence, one bit per cycle of age.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			raw_q <= 17'h00000;
		else
			raw_q <= {raw_q[15:0], raw};
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_sample;
		out_valid;
	endsequence
	sequence s_zero_pad;
		out_valid && out_r == 10'h000 && out_g == 10'h000 && out_b == 10'h000;
	endsequence

	a_out_latency: assert property (calm && !dbl |-> out_valid == $past(pix_valid, 8))
		else $error("output valid does not trail the pixel by eight cycles");
	a_single_hold: assert property (calm && !dbl && !out_valid |-> $stable(out_r) && $stable(out_g) && $stable(out_b))
		else $error("single rate output changed without a sample");
	a_zero_pad: assert property (calm && dbl && pix_valid |-> ##8 s_sample ##1 s_zero_pad)
		else $error("double rate sample not followed by a zero sample");
	a_double_idle: assert property (calm && dbl |-> out_valid == ($past(pix_valid, 8) || $past(pix_valid, 9)))
		else $error("double rate valid pattern wrong");
	a_hsync_delay: assert property (calm |-> hsync_out == $past(hsync_in, 8))
		else $error("output sync does not trail input sync by eight cycles");
	a_flag_rise: assert property (ok && rise |-> graphics_insert_flag)
		else $error("insertion flag missed its rising edge");
	a_flag_fall: assert property (ok && fall && !rise |-> !graphics_insert_flag)
		else $error("insertion flag missed its falling edge");
	a_flag_change: assert property (ok && $changed(graphics_insert_flag) |-> rise || fall)
		else $error("insertion flag moved without a delayed edge");
endmodule : plane_compositor_output_adaptor_properties
`default_nettype wire

// >>> tb/test_plane_compositor_output_adaptor.sv
// Self-checking bench for the plane compositor and output adaptor.
`timescale 1ns/100ps
`default_nettype none
`include "plane_compositor_map.svh"
module test_plane_compositor_output_adaptor
	import plane_compositor_pkg::*;
;
	typedef struct packed {
		logic [23:0] bg;
		logic [7:0]  va;
		logic [31:0] adj;
		logic [37:0] gfx;
		comp_type    vy;
		logic [29:0] exp;
	} row_type;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pix_valid = 1'b0;
	coord_type   pix_x = 11'h000;
	coord_type   pix_y = 11'h000;
	logic        hsync_in = 1'b0;
	comp_type    vid_y = 10'h040;
	comp_type    vid_c = 10'h200;
	logic        vid_cb_phase = 1'b0;
	logic [37:0] gfx_argb = 38'h0;
	logic        pready, pslverr, cur_rd_en, out_valid, hsync_out, graphics_insert_flag, rerr;
	logic [31:0] prdata, cur_rd_addr, rdata;
	logic [7:0]  cur_rd_data;
	comp_type    out_r, out_g, out_b;
	int          bad_count = 0;
	int          checked = 0;
	int          first, high;
	logic [44:0] regs [12] = '{{1'b0, `OFS_CTRL, 32'h0}, {1'b0, `OFS_BG_COLOR, 32'h0},
		{1'b0, `OFS_VID_ALPHA, 32'hFF}, {1'b0, `OFS_CUR_SIZE, 32'h0080_0080},
		{1'b0, `OFS_CLIP_MIN, 32'h0}, {1'b0, `OFS_CLIP_MAX, 32'h07FF_07FF},
		{1'b0, `OFS_CUR_PTR, 32'h0}, {1'b0, `OFS_CUR_PITCH, 32'h80},
		{1'b0, `OFS_GFX_ADJ, 32'h80}, {1'b0, `OFS_INS_DELAY, 32'h77},
		{1'b1, 12'h030, 32'h0}, {1'b1, 12'hC00, 32'h0}};
	row_type     rows [8] = '{
		'{24'h0, 8'hFF, 32'h80, {8'hFF, 10'h123, 10'h2AB, 10'h3C4}, 10'h040,
			{10'h123, 10'h2AB, 10'h3C4}},
		'{24'h010101, 8'h00, 32'h80, 38'h0, 10'h040, {3{10'h004}}},
		'{24'h0, 8'hFF, 32'h80, 38'h0, 10'h140, {3{10'h12A}}},
		'{24'h0, 8'h80, 32'h80, 38'h0, 10'h140, {3{10'h096}}},
		'{24'h0, 8'h00, 32'h80, {8'h80, {3{10'h200}}}, 10'h040, {3{10'h102}}},
		'{24'h0, 8'h00, 32'h80, {8'h40, {3{10'h3FC}}}, 10'h040, {3{10'h0FF}}},
		'{24'h0, 8'h00, 32'h40, {8'hFF, {3{10'h200}}}, 10'h040, {3{10'h100}}},
		'{24'h0, 8'h00, 32'h0010_0080, {8'hFF, {3{10'h100}}}, 10'h040, {3{10'h110}}}};
	logic [10:0] dbl [5] = '{11'h555, 11'h400, 11'h4AA, 11'h400, 11'h000};
	logic [7:0]  codes [3] = '{8'h77, 8'hF0, 8'h0F};

	// The pixel clock toggles every half period.
	always #5 pclk = ~pclk;

	plane_compositor_output_adaptor i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .pix_valid, .pix_x, .pix_y, .hsync_in, .vid_y,
		.vid_c, .vid_cb_phase, .gfx_argb, .cur_rd_en, .cur_rd_addr, .cur_rd_data, .out_valid,
		.out_r, .out_g, .out_b, .hsync_out, .graphics_insert_flag);
	cursor_memory_model i_mem (.clk(pclk), .rd_en(cur_rd_en), .rd_addr(cur_rd_addr),
		.rd_data(cur_rd_data));

	// Prints the verdict and stops the run.
	task automatic finish_test();
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// Compares one observed value against its expectation.
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer: setup, then access held until ready is sampled high.
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			finish_test();
		end
	endtask : apb

	// Presents one pixel for a single cycle.
	task automatic pix(input logic [37:0] g, input comp_type y);
		@(posedge pclk);
		pix_valid    <= 1'b1;
		gfx_argb     <= g;
		vid_y        <= y;
		vid_cb_phase <= ~vid_cb_phase;
		@(posedge pclk);
		pix_valid <= 1'b0;
	endtask : pix

	// Main sequence: reset values, blending table, cursor, double rate, flag delays, reset.
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[i]) begin
			apb(regs[i][43:32], 1'b0, 32'h0);
			check(40'({rerr, rdata}), 40'({regs[i][44], regs[i][31:0]}));
		end
		foreach (rows[i]) begin
			apb(`OFS_BG_COLOR, 1'b1, {8'h00, rows[i].bg});
			apb(`OFS_VID_ALPHA, 1'b1, {24'h0, rows[i].va});
			apb(`OFS_GFX_ADJ, 1'b1, rows[i].adj);
			pix(rows[i].gfx, rows[i].vy);
			repeat (7) @(posedge pclk);
			#1;
			check(40'({out_valid, out_r, out_g, out_b}), 40'({1'b1, rows[i].exp}));
		end
		apb(`OFS_BG_COLOR, 1'b1, 32'h0);
		apb(`OFS_VID_ALPHA, 1'b1, 32'h0);
		apb(`OFS_GFX_ADJ, 1'b1, 32'h80);
		apb(12'h564, 1'b1, 32'hFFFF);
		apb(`OFS_CUR_POS, 1'b1, 32'h0005_000A);
		apb(`OFS_CUR_PTR, 1'b1, 32'h1000);
		apb(`OFS_CUR_PITCH, 1'b1, 32'h200);
		apb(`OFS_CTRL, 1'b1, 32'h2);
		pix_x <= 11'h00D;
		pix_y <= 11'h007;
		for (int k = 0; k < 3; k++) begin
			if (k == 2)
				apb(`OFS_CLIP_MAX, 1'b1, 32'h07FF_000C);
			pix(38'h0, 10'h040);
			#1;
			check(40'({cur_rd_en, cur_rd_addr}), 40'({k != 2, 32'h1403 + (k > 0 ? 32'h1000 : 32'h0)}));
			repeat (7) @(posedge pclk);
			#1;
			check(40'(out_r == 10'h000), 40'(k == 2));
			apb(`OFS_CUR_PTR, 1'b1, 32'h2000);
		end
		apb(12'h8CC, 1'b1, 32'hFF40_80C0);
		apb(`OFS_CTRL, 1'b1, 32'h4);
		pix(38'h33, 10'h040);
		repeat (7) @(posedge pclk);
		#1;
		check(40'({out_r, out_g, out_b}), 40'({10'h101, 10'h202, 10'h303}));
		apb(`OFS_CTRL, 1'b1, 32'h1);
		repeat (40) @(posedge pclk);
		pix({8'hFF, {3{10'h155}}}, 10'h040);
		pix({8'hFF, {3{10'h0AA}}}, 10'h040);
		repeat (5) @(posedge pclk);
		foreach (dbl[i]) begin
			#1;
			check(40'({out_valid, out_r}), 40'(dbl[i]));
			@(posedge pclk);
		end
		apb(`OFS_CTRL, 1'b1, 32'h0);
		foreach (codes[i]) begin
			apb(`OFS_INS_DELAY, 1'b1, {24'h0, codes[i]});
			repeat (35) @(posedge pclk);
			first = 0;
			high = 0;
			for (int t = 0; t < 60; t++) begin
				@(posedge pclk);
				pix_valid <= t < 20;
				gfx_argb  <= {8'hFF, 30'h0};
				hsync_in  <= t == 3;
				#1;
				if (graphics_insert_flag === 1'b1) begin
					if (high == 0)
						first = t;
					high++;
				end
			end
			check(40'(first), 40'(codes[i][3:0]) + 40'h1);
			check(40'(high), 40'h14 + 40'(codes[i][7:4]) - 40'(codes[i][3:0]));
		end
		apb(`OFS_VID_ALPHA, 1'b1, 32'h12);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(`OFS_VID_ALPHA, 1'b0, 32'h0);
		check(40'(rdata), 40'hFF);
		finish_test();
	end
endmodule : test_plane_compositor_output_adaptor

bind plane_compositor_output_adaptor plane_compositor_output_adaptor_properties i_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pix_valid, .hsync_in,
	.gfx_argb, .out_valid, .out_r, .out_g, .out_b, .hsync_out, .graphics_insert_flag);
`default_nettype wire
